//--- fcd_host.sv
`timescale 1ns/1ns
module fcd_host #(
  parameter int RST_CYCLES = fcd_pkg::RST_CYC,
  parameter int BUF_WORDS  = fcd_pkg::BUF_MAX_WORDS
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                req_valid_i,
  input  wire fcd_pkg::fcd_req_t   req_i,
  input  wire logic                wdata_valid_i,
  input  wire logic [15:0]         wdata_i,
  output logic                     wdata_ready_o,
  output logic                     req_ready_o,
  output logic                     done_o,
  output logic [15:0]              rdata_o,
  output logic                     err_o,
  output fcd_pkg::fcd_mode_t       mode_o,
  output fcd_pkg::fcd_pins_t       pins_o,
  output logic [15:0]              dq_o,
  output logic                     dq_oe_o,
  input  wire logic [15:0]         dq_i
);

  typedef enum logic [7:0] {
    FCD_IDLE = 8'h01,
    FCD_WR   = 8'h02,
    FCD_WGAP = 8'h04,
    FCD_RD   = 8'h08,
    FCD_POLL = 8'h10,
    FCD_RST  = 8'h20,
    FCD_REC  = 8'h40,
    FCD_DONE = 8'h80
  } fcd_state_t;

  fcd_state_t         state;
  fcd_pkg::fcd_req_t  cur;
  logic [15:0]        wr_word [0:3];
  logic [1:0]         wr_idx;
  logic [1:0]         wr_last;
  logic [9:0]         buf_left;
  logic               in_buf;
  logic [15:0]        tmr;
  logic [15:0]        poll_cnt;
  logic               read_after;
  logic [15:0]        dq_s;

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  fcd_sync #(.W(16)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (dq_i),
    .q_o     (dq_s)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic take     = (state == FCD_IDLE) && req_valid_i;
  wire logic rdy_bit  = dq_s[fcd_pkg::SW_READY_BIT];
  wire logic err_bits = dq_s[fcd_pkg::SW_ERASE_ERR] | dq_s[fcd_pkg::SW_PROG_ERR];
  wire logic buf_need = in_buf && (buf_left != 10'h000);
  wire logic tmr_zero = (tmr == 16'h0000);
  wire logic busy_op  = (cur.op == fcd_pkg::FCD_OP_PROG) || (cur.op == fcd_pkg::FCD_OP_BPROG)
                        || (cur.op == fcd_pkg::FCD_OP_ERASE) || (cur.op == fcd_pkg::FCD_OP_SUSP)
                        || (cur.op == fcd_pkg::FCD_OP_RESUME);
  wire logic [15:0] code_of = (req_i.op == fcd_pkg::FCD_OP_READ)   ? {8'h00, fcd_pkg::CMD_READ_ARRAY}
                            : (req_i.op == fcd_pkg::FCD_OP_STATUS) ? {8'h00, fcd_pkg::CMD_READ_STATUS}
                            : (req_i.op == fcd_pkg::FCD_OP_ID)     ? {8'h00, fcd_pkg::CMD_READ_ID}
                            : (req_i.op == fcd_pkg::FCD_OP_QUERY)  ? {8'h00, fcd_pkg::CMD_READ_QUERY}
                            : (req_i.op == fcd_pkg::FCD_OP_CLEAR)  ? {8'h00, fcd_pkg::CMD_CLEAR_STAT}
                            : (req_i.op == fcd_pkg::FCD_OP_PROG)   ? {8'h00, fcd_pkg::CMD_WORD_PROG}
                            : (req_i.op == fcd_pkg::FCD_OP_BPROG)  ? {8'h00, fcd_pkg::CMD_BUF_PROG}
                            : (req_i.op == fcd_pkg::FCD_OP_ERASE)  ? {8'h00, fcd_pkg::CMD_ERASE_SETUP}
                            : (req_i.op == fcd_pkg::FCD_OP_SUSP)   ? {8'h00, fcd_pkg::CMD_SUSPEND}
                            : {8'h00, fcd_pkg::CMD_CONFIRM};
  wire logic [1:0] last_of = (req_i.op == fcd_pkg::FCD_OP_PROG)  ? 2'd1
                           : (req_i.op == fcd_pkg::FCD_OP_BPROG) ? 2'd2
                           : (req_i.op == fcd_pkg::FCD_OP_ERASE) ? 2'd1
                           : 2'd0;
  wire logic [9:0] cnt_cl  = (req_i.count > 10'(BUF_WORDS)) ? 10'(BUF_WORDS) : req_i.count;
  wire logic [9:0] cnt_one = (cnt_cl == 10'h000) ? 10'h001 : cnt_cl;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= FCD_RST;
      cur           <= '0;
      wr_word[0]    <= 16'h0000;
      wr_word[1]    <= 16'h0000;
      wr_word[2]    <= 16'h0000;
      wr_word[3]    <= 16'h0000;
      wr_idx        <= 2'd0;
      wr_last       <= 2'd0;
      buf_left      <= 10'h000;
      in_buf        <= 1'b0;
      // Power-up holds the device in reset for the full span
      tmr           <= 16'(RST_CYCLES);
      poll_cnt      <= 16'h0000;
      read_after    <= 1'b0;
      req_ready_o   <= 1'b0;
      done_o        <= 1'b0;
      err_o         <= 1'b0;
      rdata_o       <= 16'h0000;
      wdata_ready_o <= 1'b0;
      mode_o        <= fcd_pkg::FCD_MODE_ARRAY;
      pins_o        <= '{addr: 23'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b0};
      dq_o          <= 16'h0000;
      dq_oe_o       <= 1'b0;
    end else begin
      done_o        <= 1'b0;
      wdata_ready_o <= 1'b0;
      case (state)
        FCD_IDLE: begin
          req_ready_o <= 1'b1;
          if (take) begin
            req_ready_o <= 1'b0;
            cur         <= req_i;
            err_o       <= 1'b0;
            rdata_o     <= 16'h0000;
            if (req_i.op == fcd_pkg::FCD_OP_RESET) begin
              pins_o.rp_n <= 1'b0;
              tmr         <= 16'(RST_CYCLES);
              state       <= FCD_RST;
            end else begin
              wr_word[0] <= code_of;
              wr_word[1] <= (req_i.op == fcd_pkg::FCD_OP_BPROG) ? {6'h00, cnt_one - 10'h001}
                          : (req_i.op == fcd_pkg::FCD_OP_ERASE) ? {8'h00, fcd_pkg::CMD_CONFIRM}
                          : req_i.data;
              wr_word[2] <= {8'h00, fcd_pkg::CMD_CONFIRM};
              wr_idx     <= 2'd0;
              wr_last    <= last_of;
              buf_left   <= cnt_one;
              in_buf     <= 1'b0;
              // Status reads take a single data read afterwards; busy ops poll instead
              read_after <= (req_i.op == fcd_pkg::FCD_OP_STATUS);
              tmr        <= 16'(fcd_pkg::WR_CYC);
              pins_o     <= '{addr: req_i.addr, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, rp_n: 1'b1};
              dq_o       <= code_of;
              dq_oe_o    <= 1'b1;
              state      <= FCD_WR;
            end
          end
        end
        FCD_WR: begin
          if (tmr_zero) begin
            pins_o.we_n <= 1'b1;
            pins_o.ce_n <= 1'b1;
            tmr         <= 16'(fcd_pkg::WR_CYC);
            state       <= FCD_WGAP;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        FCD_WGAP: begin
          if (!tmr_zero) begin
            tmr <= tmr - 16'h0001;
          end else if (in_buf && buf_need) begin
            // Back-pressure: stall until the user offers a word
            wdata_ready_o <= 1'b1;
            if (wdata_valid_i && wdata_ready_o) begin
              wdata_ready_o <= 1'b0;
              buf_left      <= buf_left - 10'h001;
              pins_o        <= '{addr: cur.addr, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, rp_n: 1'b1};
              dq_o          <= wdata_i;
              tmr           <= 16'(fcd_pkg::WR_CYC);
              state         <= FCD_WR;
            end
          end else if (wr_idx != wr_last) begin
            if (cur.op == fcd_pkg::FCD_OP_BPROG && wr_idx == 2'd1 && !in_buf) begin
              in_buf <= 1'b1;
            end else begin
              wr_idx <= wr_idx + 2'd1;
              pins_o <= '{addr: cur.addr, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, rp_n: 1'b1};
              dq_o   <= wr_word[wr_idx + 2'd1];
              tmr    <= 16'(fcd_pkg::WR_CYC);
              state  <= FCD_WR;
            end
          end else begin
            dq_oe_o <= 1'b0;
            if (busy_op || read_after) begin
              mode_o   <= fcd_pkg::FCD_MODE_STATUS;
              poll_cnt <= 16'(fcd_pkg::POLL_LIMIT);
              pins_o   <= '{addr: cur.addr, ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, rp_n: 1'b1};
              tmr      <= 16'(fcd_pkg::RD_CYC);
              state    <= FCD_RD;
            end else begin
              // Mode held until next mode command
              if (cur.op == fcd_pkg::FCD_OP_READ) mode_o <= fcd_pkg::FCD_MODE_ARRAY;
              if (cur.op == fcd_pkg::FCD_OP_ID) mode_o <= fcd_pkg::FCD_MODE_ID;
              if (cur.op == fcd_pkg::FCD_OP_QUERY) mode_o <= fcd_pkg::FCD_MODE_QUERY;
              state <= FCD_DONE;
            end
          end
        end
        FCD_RD: begin
          if (tmr_zero) begin
            pins_o.ce_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            tmr         <= 16'(fcd_pkg::RD_CYC);
            state       <= FCD_POLL;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        FCD_POLL: begin
          if (!tmr_zero) begin
            tmr <= tmr - 16'h0001;
          end else begin
            poll_cnt <= poll_cnt - 16'h0001;
            rdata_o  <= dq_s;
            if (rdy_bit || read_after || poll_cnt == 16'h0000) begin
              // Error bits reported, left for a clear
              err_o <= err_bits || (poll_cnt == 16'h0000);
              state <= FCD_DONE;
            end else begin
              pins_o.ce_n <= 1'b0;
              pins_o.oe_n <= 1'b0;
              tmr         <= 16'(fcd_pkg::RD_CYC);
              state       <= FCD_RD;
            end
          end
        end
        FCD_RST: begin
          if (tmr_zero) begin
            pins_o.rp_n <= 1'b1;
            tmr         <= 16'(fcd_pkg::REC_CYC);
            state       <= FCD_REC;
          end else begin
            pins_o.rp_n <= 1'b0;
            tmr         <= tmr - 16'h0001;
          end
        end
        FCD_REC: begin
          if (tmr_zero) begin
            mode_o <= fcd_pkg::FCD_MODE_ARRAY;
            state  <= FCD_DONE;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        FCD_DONE: begin
          done_o <= 1'b1;
          state  <= FCD_IDLE;
        end
        default: begin
          state <= FCD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Strobe and read enable never low together
  a_we_oe_excl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(!pins_o.we_n && !pins_o.oe_n)) else $error("write and output enable both low");
  a_we_rise_hi: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(pins_o.we_n) |-> pins_o.ce_n && dq_oe_o) else $error("strobe rise without data");
  a_status_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == FCD_RD) |-> mode_o == fcd_pkg::FCD_MODE_STATUS) else $error("poll outside status");
  a_poll_deselect: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == FCD_POLL && tmr_zero && !rdy_bit && !read_after && poll_cnt != 16'h0000)
    |-> pins_o.ce_n ##1 !pins_o.ce_n) else $error("no deselect between polls");
  a_reset_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == FCD_REC && tmr_zero) |=> mode_o == fcd_pkg::FCD_MODE_ARRAY)
    else $error("mode not array after reset");
  a_mode_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == FCD_IDLE) |=> $stable(mode_o)) else $error("mode moved while idle");
  a_dq_off_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pins_o.oe_n |-> !dq_oe_o) else $error("data driven while reading");
  a_wr_pulse_len: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pins_o.we_n) |-> !pins_o.we_n[*2]) else $error("write pulse too short");
  a_rst_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pins_o.rp_n) |-> !pins_o.rp_n[*8]) else $error("reset pulse too short");
  c_prog: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    take && req_i.op == fcd_pkg::FCD_OP_PROG);
  c_erase: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    take && req_i.op == fcd_pkg::FCD_OP_ERASE);
  c_bprog: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wdata_valid_i && wdata_ready_o);
  c_err: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(err_o));

endmodule

//--- fcd_pkg.sv
package fcd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG   = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG    = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;

  // ----------------------------------------------------------------
  // Status word fields, reset value and buffer size
  // ----------------------------------------------------------------
  localparam int          SW_READY_BIT   = 7;
  localparam int          SW_ESUSP_BIT   = 6;
  localparam int          SW_ERASE_ERR   = 5;
  localparam int          SW_PROG_ERR    = 4;
  localparam int          SW_PSUSP_BIT   = 2;
  localparam logic [15:0] SW_RESET_VALUE = 16'h0080;
  localparam int          BUF_MAX_WORDS  = 512;

  // ----------------------------------------------------------------
  // Bus timing, 10 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WRITE_NS    = 100;
  localparam int T_READ_NS     = 200;
  localparam int T_RESET_NS    = 25000;
  localparam int T_REC_NS      = 200;
  localparam int WR_CYC        = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC        = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC       = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC       = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_LIMIT    = 65535;

  // ----------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FCD_OP_READ   = 4'h0,
    FCD_OP_STATUS = 4'h1,
    FCD_OP_ID     = 4'h2,
    FCD_OP_QUERY  = 4'h3,
    FCD_OP_CLEAR  = 4'h4,
    FCD_OP_PROG   = 4'h5,
    FCD_OP_BPROG  = 4'h6,
    FCD_OP_ERASE  = 4'h7,
    FCD_OP_SUSP   = 4'h8,
    FCD_OP_RESUME = 4'h9,
    FCD_OP_RESET  = 4'hA
  } fcd_op_t;

  // Device pin group driven by the controller
  typedef struct packed {
    logic [22:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rp_n;
  } fcd_pins_t;

  // One command request
  typedef struct packed {
    fcd_op_t     op;
    logic [22:0] addr;
    logic [15:0] data;
    logic [9:0]  count;
  } fcd_req_t;

  // Read mode the device is believed to be in
  typedef enum logic [1:0] {
    FCD_MODE_ARRAY  = 2'h0,
    FCD_MODE_STATUS = 2'h1,
    FCD_MODE_ID     = 2'h2,
    FCD_MODE_QUERY  = 2'h3
  } fcd_mode_t;

endpackage

//--- fcd_sync.sv
`timescale 1ns/1ns
module fcd_sync #(
  parameter int W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------
  // Three stages; a bit moves once stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1[i]  <= 1'b0;
          s2[i]  <= 1'b0;
          s3[i]  <= 1'b0;
          q_o[i] <= 1'b0;
        end else begin
          s1[i] <= d_i[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q_o[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule

//--- fcd_flash_model.sv
`timescale 1ns/1ns
module fcd_flash_model #(
  parameter int          BUSY_TICKS  = 20,
  parameter int          BLOCK_WORDS = 64,
  // Arbitrary identifier value
  parameter logic [15:0] ID_WORD     = 16'h5A5A,
  parameter logic [7:0]  QUERY_BYTE  = 8'h3C
) (
  input  wire fcd_pkg::fcd_pins_t pins_i,
  input  wire logic [15:0]        dq_i,
  input  wire logic               fail_i,
  output logic [15:0]             dq_o
);
  // ------------------------------------------------
  // Device state
  // ------------------------------------------------
  fcd_pkg::fcd_mode_t mode;
  logic [7:0]         status;
  logic [15:0]        mem [int];
  logic [15:0]        bq [$];
  logic [15:0]        rd_val = 16'h0000;
  logic               susp;
  logic               erasing;
  int                 busy_left;
  int                 setup;
  int                 bcnt;
  int                 badr;
  wire                wr_on = !pins_i.ce_n && !pins_i.we_n && pins_i.rp_n;
  wire                rd_on = !pins_i.ce_n && !pins_i.oe_n && pins_i.rp_n;

  function automatic logic [15:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  task automatic clear_all();
    mode = fcd_pkg::FCD_MODE_ARRAY;
    status = 8'h80;
    susp = 1'b0;
    erasing = 1'b0;
    busy_left = 0;
    setup = 0;
  endtask

  task automatic start(input logic er);
    erasing = er;
    busy_left = BUSY_TICKS;
    status[7] = 1'b0;
    setup = 0;
    if (fail_i) status[er ? 5 : 4] = 1'b1;
  endtask

  task automatic take(input int a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (busy_left > 0 && !susp) begin
      if (c == fcd_pkg::CMD_READ_STATUS) mode = fcd_pkg::FCD_MODE_STATUS;
      if (c == fcd_pkg::CMD_SUSPEND) begin
        susp = 1'b1;
        status[7] = 1'b1;
        status[erasing ? 6 : 2] = 1'b1;
      end
    end else if (setup == 1) begin
      mem[a] = peek(a) & d;
      start(1'b0);
    end else if (setup == 2 || setup == 5) begin
      if (c != fcd_pkg::CMD_CONFIRM) begin
        status[5:4] = 2'h3;
        setup = 0;
      end else if (setup == 2) begin
        for (int i = 0; i < BLOCK_WORDS; i++) mem.delete(a - a % BLOCK_WORDS + i);
        start(1'b1);
      end else begin
        foreach (bq[i]) mem[badr + i] = peek(badr + i) & bq[i];
        start(1'b0);
      end
    end else if (setup == 3) begin
      bcnt = int'(d[9:0]) + 1;
      badr = a;
      bq.delete();
      setup = 4;
    end else if (setup == 4) begin
      bq.push_back(d);
      if (bq.size() >= bcnt) setup = 5;
    end else begin
      case (c)
        fcd_pkg::CMD_READ_ARRAY:  mode = fcd_pkg::FCD_MODE_ARRAY;
        fcd_pkg::CMD_READ_STATUS: mode = fcd_pkg::FCD_MODE_STATUS;
        fcd_pkg::CMD_READ_ID:     mode = fcd_pkg::FCD_MODE_ID;
        fcd_pkg::CMD_READ_QUERY:  mode = fcd_pkg::FCD_MODE_QUERY;
        fcd_pkg::CMD_CLEAR_STAT:  status[5:4] = 2'h0;
        fcd_pkg::CMD_WORD_PROG:   setup = 1;
        fcd_pkg::CMD_BUF_PROG:    setup = 3;
        fcd_pkg::CMD_ERASE_SETUP: setup = 2;
        // Clears bits 7, 6 and 2
        fcd_pkg::CMD_CONFIRM:     if (susp) status = status & 8'h3B;
        default:                  setup = setup;
      endcase
      if (c == fcd_pkg::CMD_CONFIRM) susp = 1'b0;
    end
    if (setup != 0 || busy_left > 0) mode = fcd_pkg::FCD_MODE_STATUS;
  endtask

  initial clear_all();
  always @(pins_i.rp_n) if (pins_i.rp_n !== 1'b1) clear_all();

  always @(negedge wr_on) if (pins_i.rp_n === 1'b1) take(int'(pins_i.addr), dq_i);

  // Suspend freezes the remaining time
  always begin
    #100;
    if (busy_left > 0 && !susp) begin
      busy_left--;
      if (busy_left == 0) status[7] = 1'b1;
    end
  end

  always @(posedge rd_on) begin
    case (mode)
      fcd_pkg::FCD_MODE_ARRAY:  rd_val = peek(int'(pins_i.addr));
      fcd_pkg::FCD_MODE_STATUS: rd_val = {8'h00, status};
      fcd_pkg::FCD_MODE_ID:     rd_val = ID_WORD;
      default:                  rd_val = {8'h00, QUERY_BYTE};
    endcase
  end
  // Released bus shows the inverse, never a held value
  assign dq_o = rd_on ? rd_val : ~rd_val;
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------
  // Wiring
  // ------------------------------------------------
  logic                  mclk_i        = 1'b0;
  logic                  rst_n_i       = 1'b0;
  logic                  req_valid_i   = 1'b0;
  fcd_pkg::fcd_req_t     req_i         = '0;
  logic                  wdata_valid_i = 1'b0;
  logic [15:0]           wdata_i       = 16'h0000;
  logic                  fail_i        = 1'b0;
  logic                  wdata_ready_o;
  logic                  req_ready_o;
  logic                  done_o;
  logic                  err_o;
  logic                  dq_oe_o;
  logic [15:0]           rdata_o;
  logic [15:0]           dq_o;
  wire  [15:0]           dev_dq;
  fcd_pkg::fcd_mode_t    mode_o;
  fcd_pkg::fcd_pins_t    pins_o;
  int                    n_errors      = 0;
  int                    checks_done   = 0;
  fcd_pkg::fcd_op_t      ops [4] = '{fcd_pkg::FCD_OP_ID, fcd_pkg::FCD_OP_QUERY,
                                     fcd_pkg::FCD_OP_STATUS, fcd_pkg::FCD_OP_READ};
  fcd_pkg::fcd_mode_t    mds [4] = '{fcd_pkg::FCD_MODE_ID, fcd_pkg::FCD_MODE_QUERY,
                                     fcd_pkg::FCD_MODE_STATUS, fcd_pkg::FCD_MODE_ARRAY};

  always #50 mclk_i = ~mclk_i;

  fcd_host #(.RST_CYCLES(10)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .wdata_valid_i(wdata_valid_i), .wdata_i(wdata_i), .wdata_ready_o(wdata_ready_o),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o), .err_o(err_o),
    .mode_o(mode_o), .pins_o(pins_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dq_i(dq_oe_o ? dq_o : dev_dq)
  );

  fcd_flash_model FLASH (.pins_i(pins_o), .dq_i(dq_o), .fail_i(fail_i), .dq_o(dev_dq));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Buffer words are A000 plus their index
  task automatic do_op(input fcd_pkg::fcd_op_t op, input logic [22:0] a,
                       input logic [15:0] d, input logic [9:0] n);
    int k;
    int w;
    k = 0;
    w = 0;
    while (req_ready_o !== 1'b1 && k < 2000) begin
      @(posedge mclk_i);
      #10 k++;
    end
    req_i = {op, a, d, n};
    req_valid_i = 1'b1;
    wdata_valid_i = (op == fcd_pkg::FCD_OP_BPROG);
    wdata_i = 16'hA000;
    @(posedge mclk_i);
    #10 req_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 20000) begin
      @(posedge mclk_i);
      if (wdata_ready_o === 1'b1 && wdata_valid_i) w++;
      #10 wdata_i = 16'hA000 + 16'(w);
      k++;
    end
    wdata_valid_i = 1'b0;
    if (k >= 20000) chk("done_o", 16'h0001, 16'h0000);
  endtask

  initial begin
    #5000000;
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    close_out();
  end

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_i);
    #10 rst_n_i = 1'b1;
    chk("mode_o", 16'(fcd_pkg::FCD_MODE_ARRAY), 16'(mode_o));
    do_op(fcd_pkg::FCD_OP_STATUS, 23'h0, 16'h0, 10'h0);
    chk("rdata_o", 16'h0080, rdata_o);
    for (int i = 0; i < 4; i++) begin
      do_op(ops[i], 23'h0, 16'h0, 10'h0);
      chk("mode_o", 16'(mds[i]), 16'(mode_o));
      chk("dev_mode", 16'(mds[i]), 16'(FLASH.mode));
    end
    do_op(fcd_pkg::FCD_OP_PROG, 23'h5, 16'h1234, 10'h0);
    chk("rdata_o", 16'h0080, rdata_o);
    chk("err_o", 16'h0000, 16'(err_o));
    chk("dev_mode", 16'(fcd_pkg::FCD_MODE_STATUS), 16'(FLASH.mode));
    chk("word5", 16'h1234, FLASH.peek(5));
    do_op(fcd_pkg::FCD_OP_READ, 23'h0, 16'h0, 10'h0);
    chk("dev_mode", 16'(fcd_pkg::FCD_MODE_ARRAY), 16'(FLASH.mode));
    do_op(fcd_pkg::FCD_OP_BPROG, 23'h40, 16'h0, 10'h3);
    for (int i = 0; i < 3; i++) chk("bufword", 16'hA000 + 16'(i), FLASH.peek(64 + i));
    do_op(fcd_pkg::FCD_OP_ERASE, 23'h41, 16'h0, 10'h0);
    chk("erased", 16'hFFFF, FLASH.peek(66));
    chk("word5", 16'h1234, FLASH.peek(5));
    fail_i = 1'b1;
    do_op(fcd_pkg::FCD_OP_PROG, 23'h6, 16'h00FF, 10'h0);
    fail_i = 1'b0;
    chk("err_o", 16'h0001, 16'(err_o));
    chk("rdata_o", 16'h0090, rdata_o);
    do_op(fcd_pkg::FCD_OP_QUERY, 23'h0, 16'h0, 10'h0);
    do_op(fcd_pkg::FCD_OP_CLEAR, 23'h0, 16'h0, 10'h0);
    chk("dev_mode", 16'(fcd_pkg::FCD_MODE_QUERY), 16'(FLASH.mode));
    do_op(fcd_pkg::FCD_OP_STATUS, 23'h0, 16'h0, 10'h0);
    chk("rdata_o", 16'h0080, rdata_o);
    do_op(fcd_pkg::FCD_OP_SUSP, 23'h7, 16'h0, 10'h0);
    chk("rdata_o", 16'h0080, rdata_o);
    do_op(fcd_pkg::FCD_OP_RESUME, 23'h7, 16'h0, 10'h0);
    chk("rdata_o", 16'h0080, rdata_o);
    chk("err_o", 16'h0000, 16'(err_o));
    do_op(fcd_pkg::FCD_OP_STATUS, 23'h0, 16'h0, 10'h0);
    do_op(fcd_pkg::FCD_OP_RESET, 23'h0, 16'h0, 10'h0);
    chk("dev_mode", 16'(fcd_pkg::FCD_MODE_ARRAY), 16'(FLASH.mode));
    chk("dev_status", 16'h0080, {8'h00, FLASH.status});
    chk("mode_o", 16'(fcd_pkg::FCD_MODE_ARRAY), 16'(mode_o));
    close_out();
  end
endmodule
